/* core/ascp_host.sv */
// Host controller driving the converter's serial control port
`timescale 1ns/10ps
module ascp_host
  import ascp_pkg::*;
#(
  parameter int HALF_DIV = HALF_DIV_DEFAULT
) (
  // Clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic CLK_EN,
  // Mode and configuration
  input wire logic EXT_MODE_EN,
  input wire logic AUTO_BIAS,
  input wire logic THREE_WIRE,
  input wire logic REG_RESET_REQ,
  // Command port
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic CMD_READ,
  input wire logic [3:0] CMD_ADDR,
  input wire logic [15:0] CMD_WDATA,
  // Response port
  output logic RSP_VALID,
  output logic [15:0] RSP_RDATA,
  output logic BUSY,
  // Device pins
  output logic EXTENDED_MODE_PIN_N,
  output logic SERIAL_SELECT_N,
  output logic SERIAL_CLK,
  output logic SERIAL_IN_LINE_O,
  output logic SERIAL_IN_LINE_OE,
  input wire logic SERIAL_OUT_LINE
);

  localparam logic [7:0] HALF_LAST = 8'(HALF_DIV - 1);

  ascp_state_e state_r;
  logic [7:0] hc_r;
  logic [4:0] bit_idx_r;
  logic [23:0] sh_r;
  logic [15:0] rx_r;
  logic rd_r;
  logic three_r;
  logic user_r;
  logic sel_n_r;
  logic sclk_r;
  logic pin_n_r;
  logic bias_pend_r;
  logic ext_d_r;
  logic rsp_r;
  logic [15:0] rdata_r;
  logic so_meta_r;
  logic so_sync_r;
  logic half_done;
  logic mode_ok;
  logic take_bias;
  logic take_user;
  logic turned;

  assign half_done = (hc_r == 8'h00);
  // Commands only make sense while the pin selects extended mode; waiting one
  // edge after entry lets a pending bias write claim the first frame
  assign mode_ok = EXT_MODE_EN && !pin_n_r && ext_d_r && (state_r == ST_IDLE);
  assign take_bias = mode_ok && bias_pend_r;
  assign take_user = mode_ok && !bias_pend_r && CMD_VALID && !REG_RESET_REQ;
  assign CMD_READY = mode_ok && !bias_pend_r && !REG_RESET_REQ;
  // Hand the shared line to the device from the 8th bit onward of a read
  assign turned = three_r && (rd_r == DIR_READ) && (bit_idx_r >= TURN_BIT_IDX);

  assign SERIAL_SELECT_N = sel_n_r;
  assign SERIAL_CLK = sclk_r;
  assign SERIAL_IN_LINE_O = sh_r[FRAME_BITS-1];
  assign SERIAL_IN_LINE_OE = !sel_n_r && !turned;
  assign EXTENDED_MODE_PIN_N = pin_n_r;
  assign RSP_VALID = rsp_r;
  assign RSP_RDATA = rdata_r;
  assign BUSY = (state_r != ST_IDLE);

  // Device output comes from another timing domain
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      so_meta_r <= 1'b0;
      so_sync_r <= 1'b0;
    end else if (CLK_EN) begin
      so_meta_r <= SERIAL_OUT_LINE;
      so_sync_r <= so_meta_r;
    end
  end

  // Pending bias write whenever extended mode is entered while auto bias is enabled
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ext_d_r <= 1'b0;
      bias_pend_r <= 1'b0;
    end else if (CLK_EN) begin
      ext_d_r <= EXT_MODE_EN && !pin_n_r;
      if (EXT_MODE_EN && !pin_n_r && !ext_d_r && AUTO_BIAS) begin
        bias_pend_r <= 1'b1;
      end else if (take_bias || !EXT_MODE_EN) begin
        bias_pend_r <= 1'b0;
      end
    end
  end

  // Main sequencer; the serial clock is derived by dividing SYS_CLK
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      state_r <= ST_IDLE;
      hc_r <= 8'h00;
      bit_idx_r <= 5'h00;
      sh_r <= 24'h00_0000;
      rd_r <= DIR_WRITE;
      three_r <= 1'b0;
      user_r <= 1'b0;
      sel_n_r <= 1'b1;
      sclk_r <= 1'b0;
      pin_n_r <= 1'b1;
    end else if (CLK_EN) begin
      hc_r <= half_done ? 8'h00 : hc_r - 8'h01;
      case (state_r)
        ST_IDLE: begin
          sclk_r <= 1'b0;
          sel_n_r <= 1'b1;
          bit_idx_r <= 5'h00;
          if (!EXT_MODE_EN) begin
            // Pin high holds device registers at default
            pin_n_r <= 1'b1;
          end else if (pin_n_r) begin
            pin_n_r <= 1'b0;
          end else if (REG_RESET_REQ) begin
            pin_n_r <= 1'b1;
            hc_r <= PIN_RESET_CYC;
            state_r <= ST_PINRST;
          end else if (take_bias || take_user) begin
            rd_r <= take_user ? CMD_READ : DIR_WRITE;
            three_r <= THREE_WIRE;
            user_r <= take_user;
            // Direction, fixed pair, address, spare bit, data
            if (take_user) begin
              sh_r <= {CMD_READ, FIXED_PATTERN, CMD_ADDR, 1'b0,
                       CMD_READ ? DATA_RESET : CMD_WDATA};
            end else begin
              sh_r <= {DIR_WRITE, FIXED_PATTERN, REG_BIAS_ADJUST, 1'b0,
                       BIAS_FULL_RATE};
            end
            sel_n_r <= 1'b0;
            hc_r <= HALF_LAST;
            state_r <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (half_done) begin
            sclk_r <= 1'b1;
            hc_r <= HALF_LAST;
            state_r <= ST_HIGH;
          end
        end
        ST_LOW: begin
          if (half_done) begin
            sclk_r <= 1'b1;
            hc_r <= HALF_LAST;
            state_r <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (half_done) begin
            // Data moves only as the clock falls
            sclk_r <= 1'b0;
            hc_r <= HALF_LAST;
            if (bit_idx_r == LAST_BIT_IDX) begin
              state_r <= ST_HOLD;
            end else begin
              bit_idx_r <= bit_idx_r + 5'h01;
              sh_r <= {sh_r[FRAME_BITS-2:0], 1'b0};
              state_r <= ST_LOW;
            end
          end
        end
        ST_HOLD: begin
          if (half_done) begin
            // Select rises only once all 24 clocks are out
            sel_n_r <= 1'b1;
            hc_r <= HALF_LAST;
            state_r <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (half_done) begin
            state_r <= ST_IDLE;
          end
        end
        ST_PINRST: begin
          if (half_done) begin
            pin_n_r <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          sel_n_r <= 1'b1;
          sclk_r <= 1'b0;
        end
      endcase
    end
  end

  // Read data sampled late in the high phase: a full period after the
  // device moved it, which covers the two-stage synchroniser
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      rx_r <= DATA_RESET;
    end else if (CLK_EN) begin
      if (state_r == ST_HIGH && half_done && bit_idx_r >= DATA_BIT_IDX) begin
        rx_r <= {rx_r[14:0], so_sync_r};
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      rsp_r <= 1'b0;
      rdata_r <= DATA_RESET;
    end else if (CLK_EN) begin
      rsp_r <= 1'b0;
      if (state_r == ST_HOLD && half_done && user_r) begin
        rsp_r <= 1'b1;
        rdata_r <= (rd_r == DIR_READ) ? rx_r : DATA_RESET;
      end
    end
  end

  sclk_low_sel_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    sclk_r |-> !sel_n_r)
    else $error("serial clock high outside a frame");

  frame_len_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (state_r == ST_HOLD) |-> (bit_idx_r == LAST_BIT_IDX))
    else $error("frame ended without 24 bits");

  line_turn_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (three_r && rd_r && !sel_n_r && bit_idx_r >= TURN_BIT_IDX) |-> !SERIAL_IN_LINE_OE)
    else $error("host drives shared line during read data");

  sel_rise_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    $rose(sel_n_r) |-> ($past(state_r) == ST_HOLD && !sclk_r))
    else $error("select released before the 24th clock");

  sel_gap_a: assert property (@(posedge SYS_CLK) disable iff (SRST || !CLK_EN)
    $rose(sel_n_r) |=> sel_n_r)
    else $error("select not toggled between accesses");

  fixed_bits_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (state_r == ST_HIGH && bit_idx_r == 5'h01) |-> SERIAL_IN_LINE_O == FIXED_PATTERN[1])
    else $error("second frame bit is not one");

  fixed_zero_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (state_r == ST_HIGH && bit_idx_r == 5'h02) |-> SERIAL_IN_LINE_O == FIXED_PATTERN[0])
    else $error("third frame bit is not zero");

  edge_data_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    ($changed(SERIAL_IN_LINE_O) && !sel_n_r) |-> !sclk_r)
    else $error("host data changed while clock high");

  dir_bit_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (state_r == ST_HIGH && bit_idx_r == 5'h00) |-> SERIAL_IN_LINE_O == rd_r)
    else $error("direction bit wrong");

  mode_idle_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    pin_n_r |-> (sel_n_r && !sclk_r && !CMD_READY))
    else $error("access attempted outside extended mode");

  // Command and response handshake
  rsp_pulse_a: assert property (@(posedge SYS_CLK) disable iff (SRST || !CLK_EN)
    rsp_r |=> !rsp_r)
    else $error("response valid longer than one cycle");

  rsp_sel_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    rsp_r |-> sel_n_r)
    else $error("response given while select still low");

  rsp_user_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    rsp_r |-> user_r)
    else $error("response given for an internal frame");

  rsp_write_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (rsp_r && rd_r == DIR_WRITE) |-> (rdata_r == DATA_RESET))
    else $error("write response carries data");

  ready_idle_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    CMD_READY |-> !BUSY)
    else $error("command accepted while busy");

  ready_mode_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    CMD_READY |-> !pin_n_r)
    else $error("command accepted outside extended mode");

  bias_first_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    bias_pend_r |-> !CMD_READY)
    else $error("user command ahead of bias write");

  // Pin and select framing
  busy_sel_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    !BUSY |-> sel_n_r)
    else $error("select low while idle");

  oe_sel_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    SERIAL_IN_LINE_OE |-> !sel_n_r)
    else $error("host drives line outside a frame");

  four_wire_oe_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (!three_r && !sel_n_r) |-> SERIAL_IN_LINE_OE)
    else $error("four-wire data line released in frame");

  write_oe_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (rd_r == DIR_WRITE && !sel_n_r) |-> SERIAL_IN_LINE_OE)
    else $error("write data line released in frame");

  pre_turn_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (!sel_n_r && bit_idx_r < TURN_BIT_IDX) |-> SERIAL_IN_LINE_OE)
    else $error("command bits not driven");

  spare_bit_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (state_r == ST_HIGH && bit_idx_r == TURN_BIT_IDX && SERIAL_IN_LINE_OE)
    |-> !SERIAL_IN_LINE_O)
    else $error("spare frame bit not zero");

  bit_range_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    bit_idx_r <= LAST_BIT_IDX)
    else $error("bit counter beyond frame end");

  pinrst_sel_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (state_r == ST_PINRST) |-> (pin_n_r && sel_n_r))
    else $error("register reset pulse overlaps a frame");

  // Serial clock phases
  setup_low_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (state_r == ST_SETUP) |-> (!sclk_r && !sel_n_r))
    else $error("select setup phase wrong");

  low_phase_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (state_r == ST_LOW) |-> !sclk_r)
    else $error("serial clock high in low phase");

  high_phase_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (state_r == ST_HIGH) |-> sclk_r)
    else $error("serial clock low in high phase");

  hold_low_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (state_r == ST_HOLD) |-> (!sclk_r && !sel_n_r))
    else $error("hold phase framing wrong");

  gap_idle_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (state_r == ST_GAP) |-> (sel_n_r && !sclk_r))
    else $error("select not high in gap");

  idle_park_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (state_r == ST_IDLE) |-> !sclk_r)
    else $error("serial clock not parked low");

  // A low enable must freeze the link mid-frame as well
  freeze_state_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    !CLK_EN |=> $stable(state_r))
    else $error("state moved while enable low");

  freeze_clk_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
    !CLK_EN |=> ($stable(sclk_r) && $stable(sel_n_r)))
    else $error("link moved while enable low");

endmodule

/* core/ascp_pkg.sv */
// Constants for the serial control port host controller
package ascp_pkg;

  localparam int FRAME_BITS = 24;
  localparam int CMD_BITS = 8;
  localparam logic [4:0] LAST_BIT_IDX = 5'h17;
  localparam logic [4:0] TURN_BIT_IDX = 5'h07;
  localparam logic [4:0] DATA_BIT_IDX = 5'h08;
  localparam logic [1:0] FIXED_PATTERN = 2'h2;
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;

  // Device register map, one address per register
  localparam logic [3:0] REG_MAIN_CONFIGURATION = 4'h0;
  localparam logic [3:0] REG_RESERVED_SLOT_ONE = 4'h1;
  localparam logic [3:0] REG_FIRST_CHANNEL_OFFSET = 4'h2;
  localparam logic [3:0] REG_FIRST_CHANNEL_RANGE = 4'h3;
  localparam logic [3:0] REG_CALIBRATION_ADJUST = 4'h4;
  localparam logic [3:0] REG_CALIBRATION_VALUES = 4'h5;
  localparam logic [3:0] REG_BIAS_ADJUST = 4'h6;
  localparam logic [3:0] REG_INTERLEAVE_TIMING_ADJUST = 4'h7;
  localparam logic [3:0] REG_RESERVED_SLOT_EIGHT = 4'h8;
  localparam logic [3:0] REG_RESERVED_SLOT_NINE = 4'h9;
  localparam logic [3:0] REG_SECOND_CHANNEL_OFFSET = 4'ha;
  localparam logic [3:0] REG_SECOND_CHANNEL_RANGE = 4'hb;
  localparam logic [3:0] REG_SAMPLE_DELAY_COARSE = 4'hc;
  localparam logic [3:0] REG_SAMPLE_DELAY_FINE = 4'hd;
  localparam logic [3:0] REG_MULTI_CHIP_SYNC = 4'he;
  localparam logic [3:0] REG_RESERVED_SLOT_FIFTEEN = 4'hf;

  localparam logic [15:0] BIAS_FULL_RATE = 16'h1c00;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // One less than the cycles the mode pin is held high for a register reset
  localparam logic [7:0] PIN_RESET_CYC = 8'h04;
  localparam int HALF_DIV_DEFAULT = 4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_LOW = 3'b010,
    ST_HIGH = 3'b011,
    ST_HOLD = 3'b100,
    ST_GAP = 3'b101,
    ST_PINRST = 3'b110
  } ascp_state_e;

endpackage

/* sim/ascp_dev_model.sv */
// Behavioural model of the converter's serial control port
`timescale 1ns/10ps
module ascp_dev_model
  import ascp_pkg::*;
#(
  parameter logic [15:0] REG_DEFAULT = 16'h0000
) (
  // Device pins
  input wire logic mode_pin_n,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic serial_in_line,
  output logic serial_out_line,
  output logic sdo_oe
);
  logic [15:0] regs [16];
  logic [23:0] sh;
  logic [7:0] cmd;
  logic [15:0] rd;
  int cnt = 0;
  function automatic bit bad(input logic [7:0] c);
    return c[4:1] inside {4'h1, 4'h8, 4'h9, 4'hf} || c[6:5] != 2'b10;
  endfunction
  initial serial_out_line = 1'b0;
  initial sdo_oe = 1'b0;
  // A high mode pin reloads every register with its default, so contents do not survive a register reset
  always @(mode_pin_n) begin
    if (mode_pin_n !== 1'b0) begin
      foreach (regs[i]) regs[i] = REG_DEFAULT;
    end
  end
  always @(negedge sel_n) cnt = 0;
  always @(posedge sel_n) sdo_oe = 1'b0;
  // Nothing is timed, so a stopped or slow clock is harmless
  always @(posedge sclk) begin
    if (sel_n === 1'b0) begin
      sh = {sh[22:0], serial_in_line};
      cnt++;
      if (cnt == 8) cmd = sh[7:0];
      // Short frames never commit; an overlong frame commits at its 24th clock
      if (cnt == 24 && !cmd[7] && mode_pin_n === 1'b0 && !bad(cmd)) begin
        regs[cmd[4:1]] = sh[15:0];
      end
    end
  end
  always @(negedge sclk) begin
    if (sel_n === 1'b0 && cmd[7] && cnt >= 8) begin
      if (cnt == 8) rd = bad(cmd) ? 16'h0000 : regs[cmd[4:1]];
      else if (cnt <= 23) rd = rd << 1;
      serial_out_line = rd[15];
      sdo_oe = 1'b1;
    end
  end
endmodule

/* sim/ascp_host_tb.sv */
// Self-checking bench for the serial control port host controller
`timescale 1ns/10ps
module ascp_host_tb;
  import ascp_pkg::*;
  logic SYS_CLK = 1'b0;
  logic SRST = 1'b1;
  logic CLK_EN = 1'b1;
  logic EXT_MODE_EN = 1'b0;
  logic AUTO_BIAS = 1'b1;
  logic THREE_WIRE = 1'b0;
  logic REG_RESET_REQ = 1'b0;
  logic CMD_VALID = 1'b0;
  logic CMD_READ = 1'b0;
  logic [3:0] CMD_ADDR = 4'h0;
  logic [15:0] CMD_WDATA = 16'h0000;
  logic [15:0] RSP_RDATA;
  logic CMD_READY, RSP_VALID, BUSY, EXTENDED_MODE_PIN_N, SERIAL_SELECT_N, SERIAL_CLK;
  logic SERIAL_IN_LINE_O, SERIAL_IN_LINE_OE, SERIAL_OUT_LINE, dev_sdo, dev_oe, sdi_wire;
  int fails = 0;
  int compares = 0;
  int seed = 32'hc63d_db68;
  int exp_m [16];
  always #12.5 SYS_CLK = ~SYS_CLK;
  // Pull-up on the device input; one shared wire in three-wire mode
  assign sdi_wire = SERIAL_IN_LINE_OE ? SERIAL_IN_LINE_O :
    (THREE_WIRE && dev_oe ? dev_sdo : 1'b1);
  // A released four-wire output shows the inverse of its last bit, never a stale copy
  assign SERIAL_OUT_LINE = THREE_WIRE ? sdi_wire : (dev_oe ? dev_sdo : ~dev_sdo);
  ascp_host #(.HALF_DIV(2)) dut (.SYS_CLK, .SRST, .CLK_EN, .EXT_MODE_EN, .AUTO_BIAS,
    .THREE_WIRE, .REG_RESET_REQ, .CMD_VALID, .CMD_READY, .CMD_READ, .CMD_ADDR, .CMD_WDATA,
    .RSP_VALID, .RSP_RDATA, .BUSY, .EXTENDED_MODE_PIN_N, .SERIAL_SELECT_N, .SERIAL_CLK,
    .SERIAL_IN_LINE_O, .SERIAL_IN_LINE_OE, .SERIAL_OUT_LINE);
  ascp_dev_model dev (.mode_pin_n(EXTENDED_MODE_PIN_N), .sel_n(SERIAL_SELECT_N),
    .sclk(SERIAL_CLK), .serial_in_line(sdi_wire), .serial_out_line(dev_sdo), .sdo_oe(dev_oe));
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wait_for(input string nm, ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v) begin
      @(negedge SYS_CLK);
      n++;
      if (n > 5000) begin
        check(nm, 16'h0001, 16'h0000);
        give_verdict();
      end
    end
  endtask
  always @(posedge SYS_CLK) begin
    if (THREE_WIRE && SERIAL_IN_LINE_OE && dev_oe) check("line_fight", 16'h0, 16'h1);
  end
  task automatic do_cmd(input logic rd, input logic [3:0] a, input logic [15:0] d);
    bit rsv;
    rsv = a inside {4'h1, 4'h8, 4'h9, 4'hf};
    @(posedge SYS_CLK);
    CMD_VALID <= 1'b1;
    CMD_READ <= rd;
    CMD_ADDR <= a;
    CMD_WDATA <= d;
    THREE_WIRE <= 1'($random(seed));
    @(negedge SYS_CLK);
    wait_for("cmd_ready", CMD_READY, 1'b1);
    @(posedge SYS_CLK);
    CMD_VALID <= 1'b0;
    @(negedge SYS_CLK);
    wait_for("rsp_valid", RSP_VALID, 1'b1);
    check("select_release", 16'h1, {15'h0, SERIAL_SELECT_N});
    if (rd) check("read_data", rsv ? 16'h0 : 16'(exp_m[a]), RSP_RDATA);
    else check("write_rsp", 16'h0000, RSP_RDATA);
    if (!rd && !rsv) exp_m[a] = d;
  endtask
  initial begin
    foreach (exp_m[i]) exp_m[i] = 0;
    exp_m[6] = 16'h1c00;
    repeat (3) @(posedge SYS_CLK);
    SRST <= 1'b0;
    EXT_MODE_EN <= 1'b1;
    // Writes to every address, reads back, then a random mix
    for (int i = 0; i < 48; i++) begin
      do_cmd(i >= 16 && (i < 32 || 1'($random(seed))), 4'(i < 32 ? i : $random(seed)),
        16'($random(seed)));
    end
    AUTO_BIAS <= 1'b0;
    wait_for("idle", BUSY, 1'b0);
    @(posedge SYS_CLK);
    REG_RESET_REQ <= 1'b1;
    wait_for("pin_pulse", EXTENDED_MODE_PIN_N, 1'b1);
    @(posedge SYS_CLK);
    REG_RESET_REQ <= 1'b0;
    foreach (exp_m[i]) exp_m[i] = 0;
    for (int i = 0; i < 16; i++) do_cmd(1'b1, 4'(i), 16'h0000);
    do_cmd(1'b0, 4'h3, 16'h1234);
    @(posedge SYS_CLK);
    CLK_EN <= 1'b0;
    EXT_MODE_EN <= 1'b0;
    AUTO_BIAS <= 1'b1;
    repeat (4) @(negedge SYS_CLK);
    check("frozen_pin", 16'h0, {15'h0, EXTENDED_MODE_PIN_N});
    @(posedge SYS_CLK);
    CLK_EN <= 1'b1;
    repeat (4) @(negedge SYS_CLK);
    check("mode_pin", 16'h1, {15'h0, EXTENDED_MODE_PIN_N});
    check("ready_off", 16'h0, {15'h0, CMD_READY});
    @(posedge SYS_CLK);
    EXT_MODE_EN <= 1'b1;
    foreach (exp_m[i]) exp_m[i] = 0;
    exp_m[6] = 16'h1c00;
    for (int i = 0; i < 16; i++) do_cmd(1'b1, 4'(i), 16'h0000);
    give_verdict();
  end
endmodule
